//--- common/lesmr_pkg.sv
// constants, types and helpers shared by the led status and map slice
package lesmr_pkg;

  // register byte addresses
  localparam logic [7:0] LESMR_ADDR_BLUE_DUTY    = 8'h02;
  localparam logic [7:0] LESMR_ADDR_GREEN_DUTY   = 8'h03;
  localparam logic [7:0] LESMR_ADDR_RED_DUTY     = 8'h04;
  localparam logic [7:0] LESMR_ADDR_EVENT_STATUS = 8'h0C;
  localparam logic [7:0] LESMR_ADDR_SOFT_RESET   = 8'h0D;
  localparam logic [7:0] LESMR_ADDR_WHITE_DUTY   = 8'h0E;
  localparam logic [7:0] LESMR_ADDR_WHITE_CURR   = 8'h0F;
  localparam logic [7:0] LESMR_ADDR_SOURCE_MAP   = 8'h70;

  // values after reset
  localparam logic [7:0] LESMR_RST_DUTY       = 8'h00;
  localparam logic [7:0] LESMR_RST_WHITE_CURR = 8'hAF;
  localparam logic [7:0] LESMR_RST_SOURCE_MAP = 8'h39;
  localparam logic [2:0] LESMR_RST_IRQ_FLAGS  = 3'h0;
  localparam logic [7:0] LESMR_SOFT_RESET_KEY = 8'hFF;

  // event status bit positions
  localparam int LESMR_OSC_BIT      = 3;
  localparam int LESMR_SEQ1_IRQ_BIT = 2;
  localparam int LESMR_SEQ2_IRQ_BIT = 1;
  localparam int LESMR_SEQ3_IRQ_BIT = 0;

  // source map field positions
  localparam int LESMR_WHITE_SRC_LSB = 6;
  localparam int LESMR_RED_SRC_LSB   = 4;
  localparam int LESMR_GREEN_SRC_LSB = 2;
  localparam int LESMR_BLUE_SRC_LSB  = 0;

  // duty source codes
  localparam logic [1:0] LESMR_SRC_DIRECT = 2'h0;
  localparam logic [1:0] LESMR_SRC_SEQ1   = 2'h1;
  localparam logic [1:0] LESMR_SRC_SEQ2   = 2'h2;
  localparam logic [1:0] LESMR_SRC_SEQ3   = 2'h3;

  // sink current step per code, in microamps
  localparam int LESMR_CURR_STEP_UA = 100;

  // serial bus: base address, low two bits come from the select pins
  localparam logic [6:0] LESMR_BUS_BASE_ADDR = 7'h30;
  localparam logic [3:0] LESMR_BITS_PER_BYTE = 4'h8;

  // instruction opcode fields
  localparam logic [2:0] LESMR_TOP_LOOP    = 3'h5;
  localparam logic [2:0] LESMR_TOP_END     = 3'h6;
  localparam logic [2:0] LESMR_TOP_TRIGGER = 3'h7;
  localparam logic [6:0] LESMR_SET_DUTY_HI = 7'h40;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEV  = 9'h002,
    ST_AACK = 9'h004,
    ST_PTR  = 9'h008,
    ST_PACK = 9'h010,
    ST_WR   = 9'h020,
    ST_WACK = 9'h040,
    ST_RD   = 9'h080,
    ST_RACK = 9'h100
  } lesmr_state_t;

  typedef enum logic [5:0] {
    OP_SLOPE_OR_PAUSE = 6'h01,
    OP_SET_DUTY       = 6'h02,
    OP_RESTART        = 6'h04,
    OP_LOOP           = 6'h08,
    OP_END            = 6'h10,
    OP_TRIGGER        = 6'h20
  } lesmr_op_t;

  // duty source selection for one output
  function automatic logic [7:0] lesmr_pick_duty(
    input logic [1:0] sel,
    input logic [7:0] direct,
    input logic [7:0] seq1,
    input logic [7:0] seq2,
    input logic [7:0] seq3
  );
    case (sel)
      LESMR_SRC_SEQ1: lesmr_pick_duty = seq1;
      LESMR_SRC_SEQ2: lesmr_pick_duty = seq2;
      LESMR_SRC_SEQ3: lesmr_pick_duty = seq3;
      default:        lesmr_pick_duty = direct;
    endcase
  endfunction

endpackage

//--- core/lesmr_instr_dec.sv
// combinational decoder of one 16-bit sequencer instruction
`timescale 1ns/10ps
module lesmr_instr_dec
  import lesmr_pkg::*;
(
  input  wire logic [15:0] i_instr,
  output lesmr_op_t        o_op,
  output logic             o_prescale,
  output logic [5:0]       o_step_time,
  output logic             o_decrement,
  output logic [6:0]       o_increment,
  output logic [7:0]       o_duty,
  output logic [5:0]       o_loop_count,
  output logic [3:0]       o_loop_target,
  output logic             o_end_irq,
  output logic             o_end_duty_clr,
  output logic [5:0]       o_trig_wait,
  output logic [5:0]       o_trig_send
);

  always_comb begin
    o_op = OP_SLOPE_OR_PAUSE;
    if (!i_instr[15]) begin
      if (i_instr[14:0] == 15'h0000) begin
        o_op = OP_RESTART;
      end else if (i_instr[14:8] == LESMR_SET_DUTY_HI) begin
        o_op = OP_SET_DUTY;
      end else begin
        o_op = OP_SLOPE_OR_PAUSE;
      end
    end else begin
      case (i_instr[15:13])
        LESMR_TOP_LOOP:    o_op = OP_LOOP;
        LESMR_TOP_END:     o_op = OP_END;
        LESMR_TOP_TRIGGER: o_op = OP_TRIGGER;
        default:           o_op = OP_SLOPE_OR_PAUSE;
      endcase
    end
  end

  assign o_prescale     = i_instr[14];
  assign o_step_time    = i_instr[13:8];
  assign o_decrement    = i_instr[7];
  assign o_increment    = i_instr[6:0];
  assign o_duty         = i_instr[7:0];
  assign o_loop_count   = i_instr[12:7];
  assign o_loop_target  = i_instr[3:0];
  assign o_end_irq      = i_instr[12];
  assign o_end_duty_clr = i_instr[11];
  assign o_trig_wait    = i_instr[12:7];
  assign o_trig_send    = i_instr[6:1];

endmodule

//--- core/lesmr_top.sv
// status, reset, white channel and source map registers on a serial bus
// Summary of operation
// - status bit 3 shows external clock
// - engine flags in status bits 2..0
// - status read clears engine flags only
// - writing FFh to 0Dh resets registers
// - 0Eh gives white duty when direct
// - white current resets to AFh
// - map bits 7:6 pick white source
// - map bits 5:4 pick red source
// - map bits 3:2 pick green source
// - map bits 1:0 pick blue source
// - codes 01..11 select engines one..three
// - 16-bit instructions, slope and set duty
// - trigger carries wait and send channels
`timescale 1ns/10ps
module lesmr_top
  import lesmr_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_en_n,
  input  wire logic [1:0]  i_addr_sel,
  input  wire logic        i_outside_osc_active,
  input  wire logic [2:0]  i_seq_irq_set,
  input  wire logic [7:0]  i_seq1_duty,
  input  wire logic [7:0]  i_seq2_duty,
  input  wire logic [7:0]  i_seq3_duty,
  input  wire logic [15:0] i_instr,
  output logic [7:0]       o_white_duty,
  output logic [7:0]       o_red_duty,
  output logic [7:0]       o_green_duty,
  output logic [7:0]       o_blue_duty,
  output logic [7:0]       o_white_current,
  output lesmr_op_t        o_op,
  output logic             o_prescale,
  output logic [5:0]       o_step_time,
  output logic             o_decrement,
  output logic [6:0]       o_increment,
  output logic [7:0]       o_set_duty,
  output logic [5:0]       o_loop_count,
  output logic [3:0]       o_loop_target,
  output logic             o_end_irq,
  output logic             o_end_duty_clr,
  output logic [5:0]       o_trig_wait,
  output logic [5:0]       o_trig_send
);

  // bus side state
  lesmr_state_t st_r, st_nxt;
  logic [3:0]   cnt_r, cnt_nxt;
  logic [7:0]   sh_r, sh_nxt;
  logic [7:0]   ptr_r, ptr_nxt;
  logic [7:0]   tx_r, tx_nxt;
  logic         rw_r, rw_nxt;
  logic         mack_r, mack_nxt;
  logic         sda_en_n_r, sda_en_n_nxt;
  logic         scl_q_r, sda_q_r;
  logic         wr_stb, rd_ld;
  logic [7:0]   rd_data;
  logic [6:0]   dev_addr;

  // register file
  logic [2:0]   irq_flags_r, irq_flags_nxt;
  logic         osc_r, osc_nxt;
  logic [7:0]   blue_duty_r, blue_duty_nxt;
  logic [7:0]   green_duty_r, green_duty_nxt;
  logic [7:0]   red_duty_r, red_duty_nxt;
  logic [7:0]   white_duty_r, white_duty_nxt;
  logic [7:0]   white_cur_r, white_cur_nxt;
  logic [7:0]   map_r, map_nxt;
  logic         soft_rst, rd_clr;
  logic [2:0]   irq_in;

  // decoder outputs
  lesmr_op_t    dec_op;
  logic         dec_prescale, dec_decrement, dec_end_irq, dec_end_clr;
  logic [5:0]   dec_step, dec_loop_cnt, dec_wait, dec_send;
  logic [6:0]   dec_inc;
  logic [7:0]   dec_duty;
  logic [3:0]   dec_target;

  wire scl_rise = i_scl & ~scl_q_r;
  wire scl_fall = ~i_scl & scl_q_r;
  wire bus_start = scl_q_r & i_scl & sda_q_r & ~i_sda;
  wire bus_stop  = scl_q_r & i_scl & ~sda_q_r & i_sda;

  assign dev_addr = {LESMR_BUS_BASE_ADDR[6:2], i_addr_sel};

  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    case (addr)
      LESMR_ADDR_BLUE_DUTY:    reg_read = blue_duty_r;
      LESMR_ADDR_GREEN_DUTY:   reg_read = green_duty_r;
      LESMR_ADDR_RED_DUTY:     reg_read = red_duty_r;
      LESMR_ADDR_EVENT_STATUS: reg_read = {4'h0, osc_r, irq_flags_r};
      LESMR_ADDR_WHITE_DUTY:   reg_read = white_duty_r;
      LESMR_ADDR_WHITE_CURR:   reg_read = white_cur_r;
      LESMR_ADDR_SOURCE_MAP:   reg_read = map_r;
      default:                 reg_read = 8'h00;
    endcase
  endfunction

  assign rd_data = reg_read(ptr_r);

  // serial slave: address, pointer, then data bytes with auto-increment
  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    sh_nxt       = sh_r;
    ptr_nxt      = ptr_r;
    tx_nxt       = tx_r;
    rw_nxt       = rw_r;
    mack_nxt     = mack_r;
    sda_en_n_nxt = sda_en_n_r;
    wr_stb       = 1'b0;
    rd_ld        = 1'b0;
    if (bus_start) begin
      st_nxt       = ST_DEV;
      cnt_nxt      = 4'h0;
      sda_en_n_nxt = 1'b1;
    end else if (bus_stop) begin
      st_nxt       = ST_IDLE;
      sda_en_n_nxt = 1'b1;
    end else begin
      case (st_r)
        ST_IDLE: st_nxt = ST_IDLE;
        ST_DEV, ST_PTR, ST_WR: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], i_sda};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == LESMR_BITS_PER_BYTE) begin
            cnt_nxt      = 4'h0;
            sda_en_n_nxt = 1'b0;
            if (st_r == ST_DEV) begin
              if (sh_r[7:1] == dev_addr) begin
                rw_nxt = sh_r[0];
                st_nxt = ST_AACK;
              end else begin
                st_nxt       = ST_IDLE;
                sda_en_n_nxt = 1'b1;
              end
            end else if (st_r == ST_PTR) begin
              ptr_nxt = sh_r;
              st_nxt  = ST_PACK;
            end else begin
              wr_stb  = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
              st_nxt  = ST_WACK;
            end
          end
        end
        ST_AACK, ST_PACK, ST_WACK: begin
          if (scl_fall) begin
            if (st_r == ST_AACK && rw_r) begin
              rd_ld        = 1'b1;
              tx_nxt       = rd_data;
              sda_en_n_nxt = rd_data[7];
              ptr_nxt      = ptr_r + 8'h01;
              cnt_nxt      = 4'h0;
              st_nxt       = ST_RD;
            end else begin
              sda_en_n_nxt = 1'b1;
              st_nxt       = (st_r == ST_AACK) ? ST_PTR : ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt_r == 4'h7) begin
              sda_en_n_nxt = 1'b1;
              cnt_nxt      = 4'h0;
              st_nxt       = ST_RACK;
            end else begin
              cnt_nxt      = cnt_r + 4'h1;
              tx_nxt       = {tx_r[6:0], 1'b0};
              sda_en_n_nxt = tx_r[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_nxt = ~i_sda;
          end else if (scl_fall) begin
            if (mack_r) begin
              rd_ld        = 1'b1;
              tx_nxt       = rd_data;
              sda_en_n_nxt = rd_data[7];
              ptr_nxt      = ptr_r + 8'h01;
              st_nxt       = ST_RD;
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        default: st_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r       <= ST_IDLE;
      cnt_r      <= 4'h0;
      sh_r       <= 8'h00;
      ptr_r      <= 8'h00;
      tx_r       <= 8'h00;
      rw_r       <= 1'b0;
      mack_r     <= 1'b0;
      sda_en_n_r <= 1'b1;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
    end else if (i_ce) begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      sh_r       <= sh_nxt;
      ptr_r      <= ptr_nxt;
      tx_r       <= tx_nxt;
      rw_r       <= rw_nxt;
      mack_r     <= mack_nxt;
      sda_en_n_r <= sda_en_n_nxt;
      scl_q_r    <= i_scl;
      sda_q_r    <= i_sda;
    end
  end

  assign soft_rst = wr_stb && ptr_r == LESMR_ADDR_SOFT_RESET &&
                    sh_r == LESMR_SOFT_RESET_KEY;
  assign rd_clr = rd_ld && ptr_r == LESMR_ADDR_EVENT_STATUS;
  assign irq_in = {i_seq_irq_set[0], i_seq_irq_set[1], i_seq_irq_set[2]};

  always_comb begin
    irq_flags_nxt  = irq_flags_r;
    blue_duty_nxt  = blue_duty_r;
    green_duty_nxt = green_duty_r;
    red_duty_nxt   = red_duty_r;
    white_duty_nxt = white_duty_r;
    white_cur_nxt  = white_cur_r;
    map_nxt        = map_r;
    osc_nxt        = i_outside_osc_active;
    if (soft_rst) begin
      irq_flags_nxt  = LESMR_RST_IRQ_FLAGS;
      blue_duty_nxt  = LESMR_RST_DUTY;
      green_duty_nxt = LESMR_RST_DUTY;
      red_duty_nxt   = LESMR_RST_DUTY;
      white_duty_nxt = LESMR_RST_DUTY;
      white_cur_nxt  = LESMR_RST_WHITE_CURR;
      map_nxt        = LESMR_RST_SOURCE_MAP;
    end else if (wr_stb) begin
      case (ptr_r)
        LESMR_ADDR_BLUE_DUTY:  blue_duty_nxt  = sh_r;
        LESMR_ADDR_GREEN_DUTY: green_duty_nxt = sh_r;
        LESMR_ADDR_RED_DUTY:   red_duty_nxt   = sh_r;
        LESMR_ADDR_WHITE_DUTY: white_duty_nxt = sh_r;
        LESMR_ADDR_WHITE_CURR: white_cur_nxt  = sh_r;
        LESMR_ADDR_SOURCE_MAP: map_nxt        = sh_r;
        default:               map_nxt        = map_r;
      endcase
    end
    if (rd_clr) begin
      irq_flags_nxt = 3'h0;
    end
    irq_flags_nxt = irq_flags_nxt | irq_in;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_flags_r  <= LESMR_RST_IRQ_FLAGS;
      osc_r        <= 1'b0;
      blue_duty_r  <= LESMR_RST_DUTY;
      green_duty_r <= LESMR_RST_DUTY;
      red_duty_r   <= LESMR_RST_DUTY;
      white_duty_r <= LESMR_RST_DUTY;
      white_cur_r  <= LESMR_RST_WHITE_CURR;
      map_r        <= LESMR_RST_SOURCE_MAP;
    end else if (i_ce) begin
      irq_flags_r  <= irq_flags_nxt;
      osc_r        <= osc_nxt;
      blue_duty_r  <= blue_duty_nxt;
      green_duty_r <= green_duty_nxt;
      red_duty_r   <= red_duty_nxt;
      white_duty_r <= white_duty_nxt;
      white_cur_r  <= white_cur_nxt;
      map_r        <= map_nxt;
    end
  end

  lesmr_instr_dec u_dec (
    .i_instr        (i_instr),
    .o_op           (dec_op),
    .o_prescale     (dec_prescale),
    .o_step_time    (dec_step),
    .o_decrement    (dec_decrement),
    .o_increment    (dec_inc),
    .o_duty         (dec_duty),
    .o_loop_count   (dec_loop_cnt),
    .o_loop_target  (dec_target),
    .o_end_irq      (dec_end_irq),
    .o_end_duty_clr (dec_end_clr),
    .o_trig_wait    (dec_wait),
    .o_trig_send    (dec_send)
  );

  // output stage: duty routing, current code, decoded instruction
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sda_out       <= 1'b0;
      o_sda_en_n      <= 1'b1;
      o_white_duty    <= LESMR_RST_DUTY;
      o_red_duty      <= LESMR_RST_DUTY;
      o_green_duty    <= LESMR_RST_DUTY;
      o_blue_duty     <= LESMR_RST_DUTY;
      o_white_current <= LESMR_RST_WHITE_CURR;
      o_op            <= OP_RESTART;
      o_prescale      <= 1'b0;
      o_step_time     <= 6'h00;
      o_decrement     <= 1'b0;
      o_increment     <= 7'h00;
      o_set_duty      <= 8'h00;
      o_loop_count    <= 6'h00;
      o_loop_target   <= 4'h0;
      o_end_irq       <= 1'b0;
      o_end_duty_clr  <= 1'b0;
      o_trig_wait     <= 6'h00;
      o_trig_send     <= 6'h00;
    end else if (i_ce) begin
      o_sda_out       <= 1'b0;
      o_sda_en_n      <= sda_en_n_nxt;
      o_white_duty    <= lesmr_pick_duty(map_r[LESMR_WHITE_SRC_LSB +: 2],
                           white_duty_r, i_seq1_duty, i_seq2_duty,
                           i_seq3_duty);
      o_red_duty      <= lesmr_pick_duty(map_r[LESMR_RED_SRC_LSB +: 2],
                           red_duty_r, i_seq1_duty, i_seq2_duty,
                           i_seq3_duty);
      o_green_duty    <= lesmr_pick_duty(map_r[LESMR_GREEN_SRC_LSB +: 2],
                           green_duty_r, i_seq1_duty, i_seq2_duty,
                           i_seq3_duty);
      o_blue_duty     <= lesmr_pick_duty(map_r[LESMR_BLUE_SRC_LSB +: 2],
                           blue_duty_r, i_seq1_duty, i_seq2_duty,
                           i_seq3_duty);
      o_white_current <= white_cur_r;
      o_op            <= dec_op;
      o_prescale      <= dec_prescale;
      o_step_time     <= dec_step;
      o_decrement     <= dec_decrement;
      o_increment     <= dec_inc;
      o_set_duty      <= dec_duty;
      o_loop_count    <= dec_loop_cnt;
      o_loop_target   <= dec_target;
      o_end_irq       <= dec_end_irq;
      o_end_duty_clr  <= dec_end_clr;
      o_trig_wait     <= dec_wait;
      o_trig_send     <= dec_send;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_status_read;
    i_ce && rd_clr;
  endsequence

  sequence s_key_write;
    i_ce && soft_rst;
  endsequence

  a_osc_status_bit: assert property (
    s_status_read |=> tx_r[LESMR_OSC_BIT] == $past(osc_r))
    else $error("status clock bit wrong");
  a_irq_flag_set: assert property (
    i_ce && i_seq_irq_set[0] |=> irq_flags_r[LESMR_SEQ1_IRQ_BIT])
    else $error("engine one flag not set");
  a_read_clears_flags: assert property (
    s_status_read and (i_seq_irq_set == 3'h0) |=>
      irq_flags_r == 3'h0 && tx_r[2:0] == $past(irq_flags_r))
    else $error("status read did not clear flags");
  a_soft_reset_map: assert property (
    s_key_write |=> map_r == LESMR_RST_SOURCE_MAP &&
      white_duty_r == LESMR_RST_DUTY && red_duty_r == LESMR_RST_DUTY)
    else $error("soft reset missed registers");
  a_current_after_key: assert property (
    s_key_write ##1 i_ce |=> o_white_current == LESMR_RST_WHITE_CURR)
    else $error("white current not at default");
  a_white_direct: assert property (
    i_ce && map_r[7:6] == LESMR_SRC_DIRECT |=>
      o_white_duty == $past(white_duty_r))
    else $error("white direct duty wrong");
  a_red_direct: assert property (
    i_ce && map_r[5:4] == LESMR_SRC_DIRECT |=>
      o_red_duty == $past(red_duty_r))
    else $error("red direct duty wrong");
  a_green_seq2: assert property (
    i_ce && map_r[3:2] == LESMR_SRC_SEQ2 |=>
      o_green_duty == $past(i_seq2_duty))
    else $error("green engine two duty wrong");
  a_blue_seq3: assert property (
    i_ce && map_r[1:0] == LESMR_SRC_SEQ3 |=>
      o_blue_duty == $past(i_seq3_duty))
    else $error("blue engine three duty wrong");
  a_dec_restart: assert property (
    i_ce && i_instr == 16'h0000 |=> o_op == OP_RESTART)
    else $error("zero word not restart");
  a_dec_end_bits: assert property (
    i_ce && i_instr[15:13] == LESMR_TOP_END |=> o_op == OP_END &&
      o_end_irq == $past(i_instr[12]) &&
      o_end_duty_clr == $past(i_instr[11]))
    else $error("end decode wrong");
  a_dec_trigger: assert property (
    i_ce && i_instr[15:13] == LESMR_TOP_TRIGGER |=> o_op == OP_TRIGGER &&
      o_trig_send == $past(i_instr[6:1]))
    else $error("trigger decode wrong");

endmodule

//--- tb/lesmr_host_model.sv
// serial bus host model that reaches the register slice
`timescale 1ns/10ps
module lesmr_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_sda_line,
  output logic      o_scl,
  output logic      o_sda_drv
);
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // data set in low phase, line sampled late in high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda_drv = b;
    tick(3);
    o_scl = 1'b1;
    tick(3);
    r = i_sda_line;
    o_scl = 1'b0;
    tick(1);
  endtask
  task automatic start();
    o_sda_drv = 1'b1;
    tick(2);
    o_scl = 1'b1;
    tick(3);
    o_sda_drv = 1'b0;
    tick(3);
    o_scl = 1'b0;
    tick(1);
  endtask
  task automatic stop();
    o_sda_drv = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(3);
    o_sda_drv = 1'b1;
    tick(3);
  endtask
  task automatic send(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask
  task automatic wr_reg(input logic [6:0] dv, input logic [7:0] a,
                        input logic [7:0] d, output logic nak);
    logic [2:0] n;
    start();
    send({dv, 1'b0}, n[0]);
    send(a, n[1]);
    send(d, n[2]);
    stop();
    nak = |n;
  endtask
  // pointer write, repeated start, one byte read, host nak
  task automatic rd_reg(input logic [6:0] dv, input logic [7:0] a,
                        output logic [7:0] d, output logic nak);
    logic [2:0] n;
    logic r;
    start();
    send({dv, 1'b0}, n[0]);
    send(a, n[1]);
    start();
    send({dv, 1'b1}, n[2]);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    stop();
    nak = |n;
  endtask
endmodule

//--- tb/lesmr_top_tb.sv
// self-checking bench for the led status and map register slice
`timescale 1ns/10ps
module lesmr_top_tb
  import lesmr_pkg::*;
;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_ce = 1'b1;
  logic        i_scl, sda_drv, ak;
  wire logic   i_sda;
  logic [1:0]  i_addr_sel = 2'h1;
  logic        i_outside_osc_active = 1'b0;
  logic [2:0]  i_seq_irq_set = 3'h0;
  logic [7:0]  i_seq1_duty = 8'h00, i_seq2_duty = 8'h00;
  logic [7:0]  i_seq3_duty = 8'h00, rv, hold;
  logic [15:0] i_instr = 16'h0000, w;
  logic        o_sda_out, o_sda_en_n, o_prescale, o_decrement;
  logic        o_end_irq, o_end_duty_clr;
  logic [7:0]  o_white_duty, o_red_duty, o_green_duty, o_blue_duty;
  logic [7:0]  o_white_current, o_set_duty;
  logic [5:0]  o_step_time, o_loop_count, o_trig_wait, o_trig_send;
  logic [6:0]  o_increment, dev;
  logic [3:0]  o_loop_target;
  lesmr_op_t   o_op;
  logic [7:0]  mdl [256];
  logic [7:0]  ra [7] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h70, 8'h02, 8'h20};
  logic [7:0]  da [4] = '{8'h02, 8'h03, 8'h04, 8'h0E};
  logic [2:0]  flg;
  logic [31:0] seed = 32'h00000007;
  int          n_fail = 0, compares = 0, cyc = 0;
  // open-drain data line with pull-up
  assign i_sda = sda_drv & (o_sda_en_n | o_sda_out);
  always #25 i_ref_clk = ~i_ref_clk;
  lesmr_top lesmr_top_inst (.i_ref_clk, .i_rst, .i_ce, .i_scl, .i_sda,
    .o_sda_out, .o_sda_en_n, .i_addr_sel, .i_outside_osc_active,
    .i_seq_irq_set, .i_seq1_duty, .i_seq2_duty, .i_seq3_duty, .i_instr,
    .o_white_duty, .o_red_duty, .o_green_duty, .o_blue_duty,
    .o_white_current, .o_op, .o_prescale, .o_step_time, .o_decrement,
    .o_increment, .o_set_duty, .o_loop_count, .o_loop_target, .o_end_irq,
    .o_end_duty_clr, .o_trig_wait, .o_trig_send);
  lesmr_host_model lesmr_host_model_inst (.i_ref_clk, .i_sda_line(i_sda),
    .o_scl(i_scl), .o_sda_drv(sda_drv));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic close_out();
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic mrst();
    foreach (mdl[k]) mdl[k] = 8'h00;
    mdl[8'h0F] = 8'hAF;
    mdl[8'h70] = 8'h39;
    flg = 3'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    lesmr_host_model_inst.wr_reg(dev, a, d, ak);
    chk("write ack", 16'h0000, {15'h0, ak});
    if (a == 8'h0D && d == 8'hFF) mrst();
    else if (a inside {8'h02, 8'h03, 8'h04, 8'h0E, 8'h0F, 8'h70}) mdl[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = (a == 8'h0C) ? {4'h0, i_outside_osc_active, flg} : mdl[a];
    lesmr_host_model_inst.rd_reg(dev, a, rv, ak);
    if (a == 8'h0C) flg = 3'h0;
    chk("read ack", 16'h0000, {15'h0, ak});
    chk("read data", {8'h0, e}, {8'h0, rv});
  endtask
  task automatic pulse(input logic [2:0] p);
    i_seq_irq_set = p;
    tick(1);
    i_seq_irq_set = 3'h0;
    flg = flg | {p[0], p[1], p[2]};
    tick(2);
  endtask
  function automatic logic [7:0] pk(input logic [1:0] c, input logic [7:0] d);
    return (c == 2'h0) ? d : (c == 2'h1) ? i_seq1_duty :
           (c == 2'h2) ? i_seq2_duty : i_seq3_duty;
  endfunction
  task automatic chk_out();
    logic [7:0] m;
    m = mdl[8'h70];
    tick(2);
    chk("white duty", {8'h0, pk(m[7:6], mdl[8'h0E])},
        {8'h0, o_white_duty});
    chk("red duty", {8'h0, pk(m[5:4], mdl[8'h04])},
        {8'h0, o_red_duty});
    chk("green duty", {8'h0, pk(m[3:2], mdl[8'h03])},
        {8'h0, o_green_duty});
    chk("blue duty", {8'h0, pk(m[1:0], mdl[8'h02])},
        {8'h0, o_blue_duty});
    chk("white current", {8'h0, mdl[8'h0F]},
        {8'h0, o_white_current});
  endtask
  function automatic lesmr_op_t xop(input logic [15:0] v);
    if (v == 16'h0000) return OP_RESTART;
    if (v[15:8] == 8'h40) return OP_SET_DUTY;
    if (v[15:13] == 3'h5) return OP_LOOP;
    if (v[15:13] == 3'h6) return OP_END;
    if (v[15:13] == 3'h7) return OP_TRIGGER;
    return OP_SLOPE_OR_PAUSE;
  endfunction
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    mrst();
    dev = {LESMR_BUS_BASE_ADDR[6:2], i_addr_sel};
    tick(8);
    i_rst = 1'b0;
    chk_out();
    foreach (ra[k]) rd(ra[k]);
    i_outside_osc_active = 1'b1;
    pulse(3'h5);
    rd(8'h0C);
    pulse(3'h2);
    rd(8'h0C);
    rd(8'h0C);
    for (int k = 0; k < 8; k++) begin
      i_seq1_duty = rnd();
      i_seq2_duty = rnd();
      i_seq3_duty = rnd();
      foreach (da[j]) wr(da[j], rnd());
      wr(8'h70, (k < 4) ? {4{k[1:0]}} : rnd());
      wr(8'h0F, (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : rnd());
      chk_out();
    end
    rd(8'h70);
    rd(8'h0F);
    pulse(3'h1);
    wr(8'h0D, 8'h55);
    rd(8'h0E);
    wr(8'h0D, 8'hFF);
    foreach (ra[k]) rd(ra[k]);
    chk_out();
    // clock enable low must freeze the routed duty
    hold = pk(mdl[8'h70][1:0], mdl[8'h02]);
    i_ce = 1'b0;
    i_seq1_duty = ~hold;
    tick(3);
    chk("frozen blue duty", {8'h0, hold}, {8'h0, o_blue_duty});
    i_ce = 1'b1;
    chk_out();
    lesmr_host_model_inst.rd_reg(dev ^ 7'h01, 8'h0E, rv, ak);
    chk("foreign address nak", 16'h0001, {15'h0, ak});
    for (int k = 0; k < 35; k++) begin
      w = {rnd(), rnd()};
      case (k % 7)
        0: i_instr = 16'h0000;
        1: i_instr = {8'h40, w[7:0]};
        2: i_instr = {3'h5, w[12:0]};
        3: i_instr = {3'h6, w[12:0]};
        4: i_instr = {3'h7, w[12:0]};
        6: i_instr = {3'h4, w[12:0]};
        default: i_instr = {1'b0, w[14:0]} | 16'h0800;
      endcase
      tick(2);
      chk("op", {10'h0, xop(i_instr)}, {10'h0, o_op});
      chk("duty field", {8'h0, i_instr[7:0]}, {8'h0, o_set_duty});
      chk("slope fields", {1'b0, i_instr[14:0]}, {1'b0, o_prescale,
          o_step_time, o_decrement, o_increment});
      chk("loop fields", {6'h0, i_instr[12:7], i_instr[3:0]},
          {6'h0, o_loop_count, o_loop_target});
      chk("end fields", {14'h0, i_instr[12:11]},
          {14'h0, o_end_irq, o_end_duty_clr});
      chk("trigger fields", {4'h0, i_instr[12:1]},
          {4'h0, o_trig_wait, o_trig_send});
    end
    close_out();
  end
endmodule
